// ===== shared/pfs_pkg.sv
// Purpose: constants for the pin function and drive strength selector
// Assumes: 8-bit registers on a plain strobe port
// Notes: function codes are per pin, decoded in the design
`default_nettype none
package pfs_pkg;
	// register offsets
	localparam logic [3:0] ADDR_DRV0 = 4'h0;
	localparam logic [3:0] ADDR_DRV1 = 4'h1;
	localparam logic [3:0] ADDR_PA_LO = 4'h2;
	localparam logic [3:0] ADDR_PA_HI = 4'h3;
	localparam logic [3:0] ADDR_PB_LO = 4'h4;
	localparam logic [3:0] ADDR_PB_HI = 4'h5;
	// reset values and implemented-bit masks
	localparam logic [7:0] RST_VAL = 8'h00;
	localparam logic [7:0] DRV1_MASK = 8'h3F;
	localparam logic [7:0] PB_HI_MASK = 8'h3F;
	// pin function codes on the mux outputs
	localparam logic [3:0] FN_GPIO = 4'h0;
	localparam logic [3:0] FN_SERIAL_DATA_IN = 4'h1;
	localparam logic [3:0] FN_COMPARATOR_OUT = 4'h2;
	localparam logic [3:0] FN_LCD = 4'h3;
	localparam logic [3:0] FN_SERIAL_DATA_OUT = 4'h4;
	localparam logic [3:0] FN_TIMER_OUT = 4'h5;
	localparam logic [3:0] FN_ANALOG = 4'h6;
	localparam logic [3:0] FN_REF_OUT = 4'h7;
	localparam logic [3:0] FN_REF_IN = 4'h8;
	localparam logic [3:0] FN_CRYSTAL = 4'h9;
	localparam logic [3:0] FN_SERIAL_CS = 4'hA;
	localparam logic [3:0] FN_SERIAL_CLK = 4'hB;
	localparam logic [3:0] FN_COMP_IN = 4'hC;
	// drive level reported when the pin is not a push-pull output
	localparam logic [1:0] DRV_OFF = 2'h0;
endpackage
`default_nettype wire

// ===== design/pfs_top.sv
// Purpose: pin function decode for ports A and B, source current select for ports A, C and D
// Assumes: software keeps the ordering and direction duties itself
// Notes: port C/D function decode not provided; their drive fields still apply
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`default_nettype none

// Operation
// R01 - drive reg 0 bits 3..2 set port A pins 7..4 current level
// R02 - drive reg 0 bits 1..0 set port A pins 3..0 current level
// R03 - drive reg 1 bits 5..4 set port D pins 3..0 current level
// R04 - drive reg 1 bits 3..2 set port C pins 6..4 current level
// R05 - drive reg 1 bits 1..0 set port C pins 3..0 current level
// R06 - drive reg 1 bits 7..6 store nothing and read zero
// R07 - drive level applies only while the pin is a push-pull output
// R08 - port A pin 3: gpio, serial in, comparator out, lcd
// R09 - port A pin 2: gpio with interrupt 1 for codes 0-2, else lcd
// R10 - port A pin 1: gpio with interrupt 0, serial out, lcd
// R11 - port A pin 0: gpio, gpio, standard timer out, lcd
// R12 - port A pin 7: gpio, periodic timer out, lcd, analog 6
// R13 - port A pin 6: gpio with compact clock, lcd, analog 5, ref out
// R14 - port A pin 5: gpio, lcd, analog 4, reference in
// R15 - port A pin 4: gpio with periodic clock, lcd, analog 3
// R16 - port B pin 3: gpio, compact timer out, lcd, analog 7
// R17 - port B pin 2: gpio with standard clock, timer out, lcd, analog 2
// R18 - port B pin 1: gpio with interrupt 1, lcd, analog 1, crystal 2
// R19 - port B pin 0: gpio with interrupt 0, lcd, analog 0, crystal 1
// R20 - port B pin 5: gpio, serial chip select, comparator minus, lcd
// R21 - port B pin 6: gpio, serial clock, comparator plus, lcd
// R22 - software selects function before configuring and enabling peripheral
// R23 - software sets direction to input for shared digital inputs
// R24 - software disables peripheral before changing function field
module pfs_top (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	// register port
	input wire logic [3:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	// push-pull output status per pin, same clock domain
	input wire logic [7:0] PA_PUSHPULL_IN,
	input wire logic [6:0] PB_PUSHPULL_IN,
	input wire logic [6:0] PC_PUSHPULL_IN,
	input wire logic [3:0] PD_PUSHPULL_IN,
	// per-pin drive level, 2 bits per pin
	output logic [15:0] PA_DRIVE_OUT,
	output logic [13:0] PC_DRIVE_OUT,
	output logic [7:0] PD_DRIVE_OUT,
	// per-pin function code, 4 bits per pin
	output logic [31:0] PA_FUNC_OUT,
	output logic [27:0] PB_FUNC_OUT,
	// digital input routes to peripherals
	output logic PA2_EXT_EXT_INTERRUPT_1_EN_OUT,
	output logic PA1_EXT_EXT_INTERRUPT_0_EN_OUT,
	output logic PA6_CTMR_CLK_EN_OUT,
	output logic PA4_PTMR_CLK_EN_OUT,
	output logic PB2_STMR_CLK_EN_OUT,
	output logic PB1_EXT_EXT_INTERRUPT_1_EN_OUT,
	output logic PB0_EXT_EXT_INTERRUPT_0_EN_OUT
);
	// storage
	logic [7:0] drv0_r;
	logic [7:0] drv1_r;
	logic [7:0] pa_lo_r;
	logic [7:0] pa_hi_r;
	logic [7:0] pb_lo_r;
	logic [7:0] pb_hi_r;
	logic [7:0] rdata_nxt;
	logic [31:0] pa_func_nxt;
	logic [27:0] pb_func_nxt;
	logic [15:0] pa_lvl;
	logic [13:0] pc_lvl;
	logic [7:0] pd_lvl;

	// ------------------------------------------------------------
	// register writes, one process per register
	// ------------------------------------------------------------
	// drive strength register 0, every bit stored
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			drv0_r <= pfs_pkg::RST_VAL;
		else if (WR_IN && (ADDR_IN == pfs_pkg::ADDR_DRV0))
			drv0_r <= WDATA_IN;
	end

	// drive strength register 1, top two bits never stored
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			drv1_r <= pfs_pkg::RST_VAL;
		else if (WR_IN && (ADDR_IN == pfs_pkg::ADDR_DRV1))
			drv1_r <= WDATA_IN & pfs_pkg::DRV1_MASK; // R06
	end

	// port A function register, pins 3..0
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			pa_lo_r <= pfs_pkg::RST_VAL;
		else if (WR_IN && (ADDR_IN == pfs_pkg::ADDR_PA_LO))
			pa_lo_r <= WDATA_IN;
	end

	// port A function register, pins 7..4
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			pa_hi_r <= pfs_pkg::RST_VAL;
		else if (WR_IN && (ADDR_IN == pfs_pkg::ADDR_PA_HI))
			pa_hi_r <= WDATA_IN;
	end

	// port B function register, pins 3..0
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			pb_lo_r <= pfs_pkg::RST_VAL;
		else if (WR_IN && (ADDR_IN == pfs_pkg::ADDR_PB_LO))
			pb_lo_r <= WDATA_IN;
	end

	// port B function register, pins 6..4, top two bits never stored
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			pb_hi_r <= pfs_pkg::RST_VAL;
		else if (WR_IN && (ADDR_IN == pfs_pkg::ADDR_PB_HI))
			pb_hi_r <= WDATA_IN & pfs_pkg::PB_HI_MASK;
	end

	// ------------------------------------------------------------
	// register reads, data one cycle after the strobe
	// ------------------------------------------------------------
	always_comb
	begin
		unique case (ADDR_IN)
			pfs_pkg::ADDR_DRV0: rdata_nxt = drv0_r;
			pfs_pkg::ADDR_DRV1: rdata_nxt = drv1_r; // R06
			pfs_pkg::ADDR_PA_LO: rdata_nxt = pa_lo_r;
			pfs_pkg::ADDR_PA_HI: rdata_nxt = pa_hi_r;
			pfs_pkg::ADDR_PB_LO: rdata_nxt = pb_lo_r;
			pfs_pkg::ADDR_PB_HI: rdata_nxt = pb_hi_r;
			default: rdata_nxt = 8'h00; // unmapped reads zero
		endcase
	end

	// read data latch, zero outside a read
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			RDATA_OUT <= 8'h00;
		else if (RD_IN)
			RDATA_OUT <= rdata_nxt;
		else
			RDATA_OUT <= 8'h00;
	end

	// ------------------------------------------------------------
	// drive level gating per pin
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pa
			// upper nibble from bits 3..2, lower from 1..0
			assign pa_lvl[2*gi +: 2] = (gi >= 4) ? drv0_r[3:2] : drv0_r[1:0]; // R01 R02
		end
		for (gi = 0; gi < 7; gi++)
		begin : g_pc
			assign pc_lvl[2*gi +: 2] = (gi >= 4) ? drv1_r[3:2] : drv1_r[1:0]; // R04 R05
		end
		for (gi = 0; gi < 4; gi++)
		begin : g_pd
			assign pd_lvl[2*gi +: 2] = drv1_r[5:4]; // R03
		end
	endgenerate

	// port A drive outputs, held off unless push-pull
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			PA_DRIVE_OUT <= 16'h0000;
		else
			for (int i = 0; i < 8; i++)
				PA_DRIVE_OUT[2*i +: 2] <= PA_PUSHPULL_IN[i] ? pa_lvl[2*i +: 2] : pfs_pkg::DRV_OFF; // R07
	end

	// port C drive outputs, held off unless push-pull
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			PC_DRIVE_OUT <= 14'h0000;
		else
			for (int i = 0; i < 7; i++)
				PC_DRIVE_OUT[2*i +: 2] <= PC_PUSHPULL_IN[i] ? pc_lvl[2*i +: 2] : pfs_pkg::DRV_OFF; // R07
	end

	// port D drive outputs, held off unless push-pull
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
			PD_DRIVE_OUT <= 8'h00;
		else
			for (int i = 0; i < 4; i++)
				PD_DRIVE_OUT[2*i +: 2] <= PD_PUSHPULL_IN[i] ? pd_lvl[2*i +: 2] : pfs_pkg::DRV_OFF; // R07
	end

	// ------------------------------------------------------------
	// function decode for port A
	// ------------------------------------------------------------
	always_comb
	begin
		pa_func_nxt = 32'h00000000;
		// pin 0: timer output or lcd, else gpio
		unique case (pa_lo_r[1:0]) // R11
			2'h0, 2'h1: pa_func_nxt[3:0] = pfs_pkg::FN_GPIO;
			2'h2: pa_func_nxt[3:0] = pfs_pkg::FN_TIMER_OUT;
			2'h3: pa_func_nxt[3:0] = pfs_pkg::FN_LCD;
		endcase
		// pin 1: serial output or lcd, else gpio
		unique case (pa_lo_r[3:2]) // R10
			2'h0, 2'h1: pa_func_nxt[7:4] = pfs_pkg::FN_GPIO;
			2'h2: pa_func_nxt[7:4] = pfs_pkg::FN_SERIAL_DATA_OUT;
			2'h3: pa_func_nxt[7:4] = pfs_pkg::FN_LCD;
		endcase
		// pin 2: lcd on the top code only
		pa_func_nxt[11:8] = (pa_lo_r[5:4] == 2'h3) ? pfs_pkg::FN_LCD : pfs_pkg::FN_GPIO; // R09
		// pin 3: four distinct functions
		unique case (pa_lo_r[7:6]) // R08
			2'h0: pa_func_nxt[15:12] = pfs_pkg::FN_GPIO;
			2'h1: pa_func_nxt[15:12] = pfs_pkg::FN_SERIAL_DATA_IN;
			2'h2: pa_func_nxt[15:12] = pfs_pkg::FN_COMPARATOR_OUT;
			2'h3: pa_func_nxt[15:12] = pfs_pkg::FN_LCD;
		endcase
		// pin 4: lcd or analog on the upper codes, else gpio
		unique case (pa_hi_r[1:0]) // R15
			2'h0, 2'h1: pa_func_nxt[19:16] = pfs_pkg::FN_GPIO;
			2'h2: pa_func_nxt[19:16] = pfs_pkg::FN_LCD;
			2'h3: pa_func_nxt[19:16] = pfs_pkg::FN_ANALOG;
		endcase
		// pin 5: gpio, lcd, analog, reference input
		unique case (pa_hi_r[3:2]) // R14
			2'h0: pa_func_nxt[23:20] = pfs_pkg::FN_GPIO;
			2'h1: pa_func_nxt[23:20] = pfs_pkg::FN_LCD;
			2'h2: pa_func_nxt[23:20] = pfs_pkg::FN_ANALOG;
			2'h3: pa_func_nxt[23:20] = pfs_pkg::FN_REF_IN;
		endcase
		// pin 6: gpio, lcd, analog, reference output
		unique case (pa_hi_r[5:4]) // R13
			2'h0: pa_func_nxt[27:24] = pfs_pkg::FN_GPIO;
			2'h1: pa_func_nxt[27:24] = pfs_pkg::FN_LCD;
			2'h2: pa_func_nxt[27:24] = pfs_pkg::FN_ANALOG;
			2'h3: pa_func_nxt[27:24] = pfs_pkg::FN_REF_OUT;
		endcase
		// pin 7: gpio, timer output, lcd, analog
		unique case (pa_hi_r[7:6]) // R12
			2'h0: pa_func_nxt[31:28] = pfs_pkg::FN_GPIO;
			2'h1: pa_func_nxt[31:28] = pfs_pkg::FN_TIMER_OUT;
			2'h2: pa_func_nxt[31:28] = pfs_pkg::FN_LCD;
			2'h3: pa_func_nxt[31:28] = pfs_pkg::FN_ANALOG;
		endcase
	end

	// ------------------------------------------------------------
	// function decode for port B, pin 4 left as gpio
	// ------------------------------------------------------------
	always_comb
	begin
		pb_func_nxt = 28'h0000000;
		unique case (pb_lo_r[1:0]) // R19
			2'h0: pb_func_nxt[3:0] = pfs_pkg::FN_GPIO;
			2'h1: pb_func_nxt[3:0] = pfs_pkg::FN_LCD;
			2'h2: pb_func_nxt[3:0] = pfs_pkg::FN_ANALOG;
			2'h3: pb_func_nxt[3:0] = pfs_pkg::FN_CRYSTAL;
		endcase
		unique case (pb_lo_r[3:2]) // R18
			2'h0: pb_func_nxt[7:4] = pfs_pkg::FN_GPIO;
			2'h1: pb_func_nxt[7:4] = pfs_pkg::FN_LCD;
			2'h2: pb_func_nxt[7:4] = pfs_pkg::FN_ANALOG;
			2'h3: pb_func_nxt[7:4] = pfs_pkg::FN_CRYSTAL;
		endcase
		unique case (pb_lo_r[5:4]) // R17
			2'h0: pb_func_nxt[11:8] = pfs_pkg::FN_GPIO;
			2'h1: pb_func_nxt[11:8] = pfs_pkg::FN_TIMER_OUT;
			2'h2: pb_func_nxt[11:8] = pfs_pkg::FN_LCD;
			2'h3: pb_func_nxt[11:8] = pfs_pkg::FN_ANALOG;
		endcase
		unique case (pb_lo_r[7:6]) // R16
			2'h0: pb_func_nxt[15:12] = pfs_pkg::FN_GPIO;
			2'h1: pb_func_nxt[15:12] = pfs_pkg::FN_TIMER_OUT;
			2'h2: pb_func_nxt[15:12] = pfs_pkg::FN_LCD;
			2'h3: pb_func_nxt[15:12] = pfs_pkg::FN_ANALOG;
		endcase
		unique case (pb_hi_r[3:2]) // R20
			2'h0: pb_func_nxt[23:20] = pfs_pkg::FN_GPIO;
			2'h1: pb_func_nxt[23:20] = pfs_pkg::FN_SERIAL_CS;
			2'h2: pb_func_nxt[23:20] = pfs_pkg::FN_COMP_IN;
			2'h3: pb_func_nxt[23:20] = pfs_pkg::FN_LCD;
		endcase
		unique case (pb_hi_r[5:4]) // R21
			2'h0: pb_func_nxt[27:24] = pfs_pkg::FN_GPIO;
			2'h1: pb_func_nxt[27:24] = pfs_pkg::FN_SERIAL_CLK;
			2'h2: pb_func_nxt[27:24] = pfs_pkg::FN_COMP_IN;
			2'h3: pb_func_nxt[27:24] = pfs_pkg::FN_LCD;
		endcase
	end

	// ------------------------------------------------------------
	// registered function outputs and input routes
	// ------------------------------------------------------------
	// function codes, two edges after the register write
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			PA_FUNC_OUT <= 32'h00000000;
			PB_FUNC_OUT <= 28'h0000000;
		end
		else
		begin
			PA_FUNC_OUT <= pa_func_nxt;
			PB_FUNC_OUT <= pb_func_nxt;
		end
	end

	// input routes, high while a code keeps the gpio-with-input option
	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			PA2_EXT_EXT_INTERRUPT_1_EN_OUT <= 1'b0;
			PA1_EXT_EXT_INTERRUPT_0_EN_OUT <= 1'b0;
			PA6_CTMR_CLK_EN_OUT <= 1'b0;
			PA4_PTMR_CLK_EN_OUT <= 1'b0;
			PB2_STMR_CLK_EN_OUT <= 1'b0;
			PB1_EXT_EXT_INTERRUPT_1_EN_OUT <= 1'b0;
			PB0_EXT_EXT_INTERRUPT_0_EN_OUT <= 1'b0;
		end
		else
		begin
			PA2_EXT_EXT_INTERRUPT_1_EN_OUT <= (pa_lo_r[5:4] != 2'h3); // R09
			PA1_EXT_EXT_INTERRUPT_0_EN_OUT <= (pa_lo_r[3] == 1'b0); // R10
			PA6_CTMR_CLK_EN_OUT <= (pa_hi_r[5:4] == 2'h0); // R13
			PA4_PTMR_CLK_EN_OUT <= (pa_hi_r[1] == 1'b0); // R15
			PB2_STMR_CLK_EN_OUT <= (pb_lo_r[5:4] == 2'h0); // R17
			PB1_EXT_EXT_INTERRUPT_1_EN_OUT <= (pb_lo_r[3:2] == 2'h0); // R18
			PB0_EXT_EXT_INTERRUPT_0_EN_OUT <= (pb_lo_r[1:0] == 2'h0); // R19
		end
	end
endmodule // pfs_top
`default_nettype wire

// ===== tb/pfs_checker.sv
// Purpose: port-level assertions for the pin function and drive selector
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind at the foot of this file
`default_nettype none
module pfs_checker (
	// clock, reset and register port
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [3:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [7:0] RDATA_OUT,
	// pin status and decoded results
	input wire logic [7:0] PA_PUSHPULL_IN,
	input wire logic [6:0] PC_PUSHPULL_IN,
	input wire logic [3:0] PD_PUSHPULL_IN,
	input wire logic [15:0] PA_DRIVE_OUT,
	input wire logic [13:0] PC_DRIVE_OUT,
	input wire logic [7:0] PD_DRIVE_OUT,
	input wire logic [31:0] PA_FUNC_OUT,
	input wire logic [27:0] PB_FUNC_OUT
);
	logic [7:0] wd_d1_r;
	logic [7:0] wd_d2_r;
	// write data two cycles back, for the drive level checks
	always_ff @(posedge CLK_IN)
	begin
		wd_d1_r <= WDATA_IN;
		wd_d2_r <= wd_d1_r;
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// register write, then the pin held as push-pull output
	sequence drv_wr(logic [3:0] a, logic pp);
		WR_IN && ADDR_IN == a ##1 pp;
	endsequence
	rd_idle_zero_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
		else $error("read data not zero outside a read");
	drv1_top_zero_a: assert property (RD_IN && ADDR_IN == pfs_pkg::ADDR_DRV1
		|=> RDATA_OUT[7:6] == 2'h0) else $error("drive reg 1 top bits not zero");
	pa_low_drv_a: assert property (drv_wr(pfs_pkg::ADDR_DRV0, PA_PUSHPULL_IN[0])
		|=> PA_DRIVE_OUT[1:0] == wd_d2_r[1:0]) else $error("port A low drive wrong");
	pa_high_drv_a: assert property (drv_wr(pfs_pkg::ADDR_DRV0, PA_PUSHPULL_IN[7])
		|=> PA_DRIVE_OUT[15:14] == wd_d2_r[3:2]) else $error("port A high drive wrong");
	pd_drv_a: assert property (drv_wr(pfs_pkg::ADDR_DRV1, PD_PUSHPULL_IN[3])
		|=> PD_DRIVE_OUT[7:6] == wd_d2_r[5:4]) else $error("port D drive wrong");
	pc_high_drv_a: assert property (drv_wr(pfs_pkg::ADDR_DRV1, PC_PUSHPULL_IN[6])
		|=> PC_DRIVE_OUT[13:12] == wd_d2_r[3:2]) else $error("port C high drive wrong");
	pc_low_drv_a: assert property (drv_wr(pfs_pkg::ADDR_DRV1, PC_PUSHPULL_IN[0])
		|=> PC_DRIVE_OUT[1:0] == wd_d2_r[1:0]) else $error("port C low drive wrong");
	drv_gated_off_a: assert property (!PA_PUSHPULL_IN[4]
		|=> PA_DRIVE_OUT[9:8] == pfs_pkg::DRV_OFF) else $error("drive not gated off");
	pa0_timer_a: assert property (WR_IN && ADDR_IN == pfs_pkg::ADDR_PA_LO
		&& WDATA_IN[1:0] == 2'h2 |-> ##2 PA_FUNC_OUT[3:0] == pfs_pkg::FN_TIMER_OUT)
		else $error("port A pin 0 timer output not selected");
	pb1_crystal_a: assert property (WR_IN && ADDR_IN == pfs_pkg::ADDR_PB_LO
		&& WDATA_IN[3:2] == 2'h3 |-> ##2 PB_FUNC_OUT[7:4] == pfs_pkg::FN_CRYSTAL)
		else $error("port B pin 1 crystal not selected");
endmodule // pfs_checker
bind pfs_top pfs_checker pfs_checker_inst (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
	.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
	.RDATA_OUT(RDATA_OUT), .PA_PUSHPULL_IN(PA_PUSHPULL_IN), .PC_PUSHPULL_IN(PC_PUSHPULL_IN),
	.PD_PUSHPULL_IN(PD_PUSHPULL_IN), .PA_DRIVE_OUT(PA_DRIVE_OUT), .PC_DRIVE_OUT(PC_DRIVE_OUT),
	.PD_DRIVE_OUT(PD_DRIVE_OUT), .PA_FUNC_OUT(PA_FUNC_OUT), .PB_FUNC_OUT(PB_FUNC_OUT));
`default_nettype wire

// ===== tb/test_pin_function_and_drive_select.sv
// Purpose: self-checking bench for the pin function and drive selector
// Assumes: 20 MHz clock, strobe register port, read data one cycle later
// Notes: table rows set every function field code; reset and gating tested by hand
`default_nettype none
module test_pin_function_and_drive_select;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] r; logic [1:0] s;
		logic [31:0] o; logic [6:0] e;} pfs_row_t;
	logic clk = 1'b0;
	logic rst, wr, rd;
	logic [3:0] addr, pd_pp;
	logic [7:0] wdata, rdata, pa_pp, pd_drv;
	logic [6:0] pc_pp;
	logic [15:0] pa_drv;
	logic [13:0] pc_drv;
	logic [31:0] pa_fn;
	logic [27:0] pb_fn;
	wire [6:0] en;
	int mismatches = 0;
	int total_checks = 0;
	// address, write data, read back, output group, outputs, input routes
	pfs_row_t rows [21] = '{
		'{4'h0,8'hE4,8'hE4,2'h1,32'h0000_5500,7'h7F}, '{4'h0,8'h1B,8'h1B,2'h1,32'h0000_AAFF,7'h7F},
		'{4'h1,8'hE4,8'h24,2'h2,32'h002A_9500,7'h7F}, '{4'h1,8'h1B,8'h1B,2'h2,32'h0015_6AFF,7'h7F},
		'{4'hA,8'hFF,8'h00,2'h0,32'h0000_0000,7'h7F},
		'{4'h2,8'h55,8'h55,2'h0,32'h0000_1000,7'h7F}, '{4'h2,8'hAA,8'hAA,2'h0,32'h0000_2045,7'h5F},
		'{4'h2,8'hFF,8'hFF,2'h0,32'h0000_3333,7'h1F}, '{4'h2,8'h00,8'h00,2'h0,32'h0000_0000,7'h7F},
		'{4'h3,8'h55,8'h55,2'h0,32'h5330_0000,7'h6F}, '{4'h3,8'hAA,8'hAA,2'h0,32'h3663_0000,7'h67},
		'{4'h3,8'hFF,8'hFF,2'h0,32'h6786_0000,7'h67}, '{4'h3,8'h00,8'h00,2'h0,32'h0000_0000,7'h7F},
		'{4'h4,8'h55,8'h55,2'h3,32'h0000_5533,7'h78}, '{4'h4,8'hAA,8'hAA,2'h3,32'h0000_3366,7'h78},
		'{4'h4,8'hFF,8'hFF,2'h3,32'h0000_6699,7'h78}, '{4'h4,8'h00,8'h00,2'h3,32'h0000_0000,7'h7F},
		'{4'h5,8'h55,8'h15,2'h3,32'h0BA0_0000,7'h7F}, '{4'h5,8'hAA,8'h2A,2'h3,32'h0CC0_0000,7'h7F},
		'{4'h5,8'hFF,8'h3F,2'h3,32'h0330_0000,7'h7F}, '{4'h5,8'h00,8'h00,2'h3,32'h0000_0000,7'h7F}};
	// 20 MHz system clock
	always #25 clk = ~clk;
	pfs_top pfs_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PA_PUSHPULL_IN(pa_pp),
		.PB_PUSHPULL_IN(7'h7F), .PC_PUSHPULL_IN(pc_pp), .PD_PUSHPULL_IN(pd_pp),
		.PA_DRIVE_OUT(pa_drv), .PC_DRIVE_OUT(pc_drv), .PD_DRIVE_OUT(pd_drv),
		.PA_FUNC_OUT(pa_fn), .PB_FUNC_OUT(pb_fn), .PA2_EXT_EXT_INTERRUPT_1_EN_OUT(en[6]),
		.PA1_EXT_EXT_INTERRUPT_0_EN_OUT(en[5]), .PA6_CTMR_CLK_EN_OUT(en[4]), .PA4_PTMR_CLK_EN_OUT(en[3]),
		.PB2_STMR_CLK_EN_OUT(en[2]), .PB1_EXT_EXT_INTERRUPT_1_EN_OUT(en[1]), .PB0_EXT_EXT_INTERRUPT_0_EN_OUT(en[0]));
	// compare and count
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one bus cycle; signals change just after the edge, outputs settled on return
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		#1;
	endtask
	// output group chosen by a table row
	function automatic logic [31:0] obs(input logic [1:0] s);
		case (s)
			2'h0: return pa_fn;
			2'h1: return {16'h0000, pa_drv};
			2'h2: return {10'h000, pd_drv, pc_drv};
			default: return {4'h0, pb_fn};
		endcase
	endfunction
	// verdict and end of run
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// main sequence: reset, table, hand-written cases
	initial
	begin
		rst <= 1'b1;
		pa_pp <= 8'hFF;
		pc_pp <= 7'h7F;
		pd_pp <= 4'hF;
		repeat (4) bus(1'b0, 1'b0, 4'h0, 8'h00);
		rst <= 1'b0;
		for (int a = 0; a < 6; a++)
		begin
			bus(1'b0, 1'b1, 4'(a), 8'h00);
			check("reset value", {24'h0, rdata}, 32'h0);
		end
		foreach (rows[i])
		begin
			bus(1'b1, 1'b0, rows[i].a, rows[i].d);
			bus(1'b0, 1'b1, rows[i].a, 8'h00);
			check("read back", {24'h0, rdata}, {24'h0, rows[i].r});
			if (rows[i].s inside {2'h1, 2'h2})
				check("drive level", obs(rows[i].s), rows[i].o);
			else
				check("pin function", obs(rows[i].s), rows[i].o);
			check("input routes", {25'h0, en}, {25'h0, rows[i].e});
		end
		// drop push-pull on some pins: their levels fall to off
		pa_pp <= 8'h0F;
		pc_pp <= 7'h00;
		pd_pp <= 4'hA;
		repeat (2) bus(1'b0, 1'b0, 4'h0, 8'h00);
		check("drive gated A", obs(2'h1), 32'h0000_00FF);
		check("drive gated C D", obs(2'h2), 32'h0011_0000);
		// back-to-back writes, unused drive bits read zero
		bus(1'b1, 1'b0, 4'h1, 8'hFF);
		bus(1'b1, 1'b0, 4'h5, 8'hC0);
		bus(1'b0, 1'b1, 4'h1, 8'h00);
		check("drive reg 1 top", {24'h0, rdata}, 32'h0000_003F);
		// mid-run reset: outputs drop and registers clear while held, drive reg 0 reads back zero after it
		rst <= 1'b1;
		repeat (2) bus(1'b0, 1'b0, 4'h0, 8'h00);
		check("routes in reset", {25'h0, en}, 32'h0);
		check("drive in reset", obs(2'h1), 32'h0);
		rst <= 1'b0;
		bus(1'b0, 1'b1, 4'h0, 8'h00);
		check("drive reg 0 after reset", {24'h0, rdata}, 32'h0);
		check("routes after reset", {25'h0, en}, 32'h0000_007F);
		complete_run();
	end
	// watchdog: the sequence needs under 100 cycles
	initial
	begin
		repeat (2000) @(posedge clk);
		mismatches++;
		complete_run();
	end
endmodule // test_pin_function_and_drive_select
`default_nettype wire
